// ===== shared/ufc_pkg.sv
// constants and types for the uart alternate-function control block
package ufc_pkg;
  localparam int        NUM_CHAN       = 2;
  localparam int        CHAN_W         = 1;
  localparam int        ADDR_W         = 3;
  localparam int        DATA_W         = 8;
  localparam int        LCR_SEL_W      = 3;
  localparam int        DLY_W          = 3;
  // register placement inside the uart register window
  localparam logic [ADDR_W-1:0]    ALT_FUNC_ADDR  = 3'h2;
  localparam logic [LCR_SEL_W-1:0] LCR_SEL_ALT    = 3'h4;
  localparam logic [DATA_W-1:0]    ALT_FUNC_RESET = 8'h00;
  localparam logic [DATA_W-1:0]    READ_IDLE      = 8'h00;
  // field positions of alternate_function_control
  localparam int        BIT_BCAST      = 0;
  localparam int        BIT_INFRARED   = 1;
  localparam int        BIT_HALF_DUP   = 2;
  localparam int        BIT_LARGE_BLK  = 3;
  localparam int        BIT_SNOOP      = 4;
  localparam int        DLY_LSB        = 5;
  localparam int        DLY_MSB        = 7;
  localparam logic [DLY_W-1:0] DLY_NONE = 3'h0;
  localparam logic [DLY_W-1:0] DLY_STEP = 3'h1;
  // infrared signalling is only specified up to this rate, in bit/s
  localparam int        IRDA_MAX_BAUD  = 115200;

  typedef enum logic [1:0] {
    DE_IDLE,
    DE_ARMED,
    DE_ACTIVE,
    DE_TRAIL
  } ufc_de_state_type;
endpackage : ufc_pkg

// ===== hdl/ufc_de_timer.sv
// driver-enable sequencer with trailing hold for one channel
`timescale 1ns/1ns
`default_nettype none
module ufc_de_timer
  import ufc_pkg::*;
(
  input  wire logic             i_ref_clk,    // core clock
  input  wire logic             i_srst,       // sync reset, active high
  input  wire logic             i_enable,     // half-duplex mode on
  input  wire logic [DLY_W-1:0] i_delay,      // trailing hold in bit times
  input  wire logic             i_pending,    // fifo or shift reg holds data
  input  wire logic             i_stop_warn,  // one bit before first stop
  input  wire logic             i_thr_write,  // host wrote transmit fifo
  input  wire logic             i_bit_tick,   // one pulse per bit time
  output logic                  o_de          // line driver enable
);
  ufc_de_state_type state_r;
  ufc_de_state_type state_nxt;
  logic [DLY_W-1:0] cnt_r;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      DE_IDLE:
        if (i_enable && i_pending)
          state_nxt = i_stop_warn ? DE_ACTIVE : DE_ARMED;
      DE_ARMED:
        if (!i_enable || !i_pending)
          state_nxt = DE_IDLE;
        else if (i_stop_warn)
          state_nxt = DE_ACTIVE;
      DE_ACTIVE:
        if (!i_enable)
          state_nxt = DE_IDLE;
        else if (!i_pending && !i_thr_write)
          state_nxt = (i_delay == DLY_NONE) ? DE_IDLE : DE_TRAIL;
      DE_TRAIL:
        if (!i_enable)
          state_nxt = DE_IDLE;
        else if (i_pending || i_thr_write)
          state_nxt = DE_ACTIVE;
        else if (i_bit_tick && (cnt_r + DLY_STEP == i_delay))
          state_nxt = DE_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      state_r <= DE_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst || state_r != DE_TRAIL)
      cnt_r <= DLY_NONE;
    else if (i_bit_tick)
      cnt_r <= cnt_r + DLY_STEP;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      o_de <= 1'b0;
    else
      o_de <= (state_nxt == DE_ACTIVE) || (state_nxt == DE_TRAIL);
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  sequence s_drain_start;
    o_de && i_enable && !i_pending && !i_thr_write && i_delay == DLY_STEP;
  endsequence
  sequence s_quiet_tick;
    i_enable && !i_pending && !i_thr_write && i_bit_tick;
  endsequence

  a_de_off_disabled : assert property (!i_enable |=> !o_de)
    else $error("driver enable high while half duplex off");
  a_de_hold_pending : assert property (o_de && i_enable && i_pending |=> o_de)
    else $error("driver enable dropped with data pending");
  a_de_rise_warn : assert property (i_enable && i_pending && i_stop_warn |=> o_de)
    else $error("driver enable missing before first stop bit");
  a_trail_one_bit : assert property (s_drain_start ##1 s_quiet_tick |=> !o_de)
    else $error("trailing hold of one bit time not ended");
endmodule : ufc_de_timer
`default_nettype wire

// ===== hdl/ufc_top.sv
// alternate-function control for a two-channel uart
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module ufc_top
  import ufc_pkg::*;
(
  input  wire logic                 i_ref_clk,      // 250 MHz core clock
  input  wire logic                 i_srst,         // sync reset, active high
  input  wire logic [ADDR_W-1:0]    i_addr,         // register address
  input  wire logic [DATA_W-1:0]    i_wdata,        // write data
  input  wire logic                 i_wr,           // write strobe
  input  wire logic                 i_rd,           // read strobe
  input  wire logic [CHAN_W-1:0]    i_chan_sel,     // channel addressed
  input  wire logic [LCR_SEL_W-1:0] i_lcr_upper,    // line control bits 7:5
  input  wire logic [NUM_CHAN-1:0]  i_fifo_empty,   // transmit fifo empty
  input  wire logic [NUM_CHAN-1:0]  i_tsr_empty,    // shift register empty
  input  wire logic [NUM_CHAN-1:0]  i_thr_write,    // fifo write pulse
  input  wire logic [NUM_CHAN-1:0]  i_stop_warn,    // bit before first stop
  input  wire logic [NUM_CHAN-1:0]  i_bit_tick,     // bit-time enable
  input  wire logic [NUM_CHAN-1:0]  i_tx_int_req,   // raw transmit interrupt
  input  wire logic [NUM_CHAN-1:0]  i_rx_tmo_req,   // raw char timeout
  output logic      [DATA_W-1:0]    o_rdata,        // read data
  output logic      [NUM_CHAN-1:0]  o_line_driver_enable_out, // transceiver enable
  output logic      [NUM_CHAN-1:0]  o_tx_int,       // gated transmit interrupt
  output logic      [NUM_CHAN-1:0]  o_rx_enable,    // receiver allowed
  output logic      [NUM_CHAN-1:0]  o_rx_tmo_int,   // gated timeout interrupt
  output logic      [NUM_CHAN-1:0]  o_infrared_mode_enable  // infrared coding on
);
  logic [DATA_W-1:0] alt_r [NUM_CHAN];
  logic              wr_hit;
  logic              rd_hit;
  logic              bcast_sel;
  logic [NUM_CHAN-1:0] tx_pending;
  logic [NUM_CHAN-1:0] de_w;

  assign wr_hit    = i_wr && (i_addr == ALT_FUNC_ADDR) && (i_lcr_upper == LCR_SEL_ALT);
  assign rd_hit    = i_rd && (i_addr == ALT_FUNC_ADDR) && (i_lcr_upper == LCR_SEL_ALT);
  // the addressed channel's own bit decides; software sets it there first
  assign bcast_sel = alt_r[i_chan_sel][BIT_BCAST];

  // read data stand for one cycle only; other addresses and idle read zero
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
      o_rdata <= READ_IDLE;
    else if (rd_hit)
      o_rdata <= alt_r[i_chan_sel];
    else
      o_rdata <= READ_IDLE;
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++)
    begin : g_chan
      logic half_dup;
      logic infrared;
      logic large_blk;
      logic snoop;
      logic sel_me;

      assign half_dup  = alt_r[ch][BIT_HALF_DUP];
      assign infrared  = alt_r[ch][BIT_INFRARED];
      assign large_blk = alt_r[ch][BIT_LARGE_BLK];
      assign snoop     = alt_r[ch][BIT_SNOOP];
      assign sel_me    = (i_chan_sel == CHAN_W'(ch));
      assign tx_pending[ch] = !(i_fifo_empty[ch] && i_tsr_empty[ch]);

      always_ff @(posedge i_ref_clk)
      begin
        if (i_srst)
          alt_r[ch] <= ALT_FUNC_RESET;
        else if (wr_hit && (sel_me || bcast_sel))
          alt_r[ch] <= i_wdata;
      end

      always_ff @(posedge i_ref_clk)
      begin
        if (i_srst)
          o_infrared_mode_enable[ch] <= 1'b0;
        else
          o_infrared_mode_enable[ch] <= infrared;
      end

      always_ff @(posedge i_ref_clk)
      begin
        if (i_srst)
          o_tx_int[ch] <= 1'b0;
        else if (half_dup && !large_blk)
          o_tx_int[ch] <= i_tx_int_req[ch] && !tx_pending[ch];
        else
          o_tx_int[ch] <= i_tx_int_req[ch];
      end

      always_ff @(posedge i_ref_clk)
      begin
        if (i_srst)
          o_rx_enable[ch] <= 1'b1;
        else if (half_dup)
          o_rx_enable[ch] <= snoop || !(tx_pending[ch] || de_w[ch]);
        else if (infrared)
          o_rx_enable[ch] <= snoop;
        else
          o_rx_enable[ch] <= 1'b1;
      end

      always_ff @(posedge i_ref_clk)
      begin
        if (i_srst)
          o_rx_tmo_int[ch] <= 1'b0;
        else
          o_rx_tmo_int[ch] <= i_rx_tmo_req[ch] && snoop;
      end

      ufc_de_timer u_de_timer (
        .i_ref_clk   (i_ref_clk),
        .i_srst      (i_srst),
        .i_enable    (half_dup),
        .i_delay     (alt_r[ch][DLY_MSB:DLY_LSB]),
        .i_pending   (tx_pending[ch]),
        .i_stop_warn (i_stop_warn[ch]),
        .i_thr_write (i_thr_write[ch]),
        .i_bit_tick  (i_bit_tick[ch]),
        .o_de        (de_w[ch])
      );
      // driver enable is the timer's own flop, no extra stage
      assign o_line_driver_enable_out[ch] = de_w[ch];
    end
  endgenerate

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  sequence s_bcast_write;
    wr_hit && bcast_sel;
  endsequence
  sequence s_plain_write_ch0;
    wr_hit && !bcast_sel && i_chan_sel == CHAN_W'(0);
  endsequence

  a_bcast_both_ch : assert property (s_bcast_write |=>
      alt_r[0] == $past(i_wdata) && alt_r[1] == $past(i_wdata))
    else $error("broadcast write missed a channel");
  a_private_copy : assert property (s_plain_write_ch0 |=>
      alt_r[1] == $past(alt_r[1]) && alt_r[0] == $past(i_wdata))
    else $error("single write leaked into other channel");
  a_window_closed : assert property (i_wr && i_lcr_upper != LCR_SEL_ALT |=>
      alt_r[0] == $past(alt_r[0]) && alt_r[1] == $past(alt_r[1]))
    else $error("register written outside its window");
  a_read_one_cycle : assert property (rd_hit ##1 !rd_hit |=> o_rdata == READ_IDLE)
    else $error("read data outlived its cycle");
  a_ir_after_write : assert property ((s_plain_write_ch0 and i_wdata[BIT_INFRARED]) |=>
      ##1 o_infrared_mode_enable[0])
    else $error("infrared mode not taken after write");
  a_tx_holdoff : assert property (alt_r[0][BIT_HALF_DUP] && !alt_r[0][BIT_LARGE_BLK]
      && tx_pending[0] |=> !o_tx_int[0])
    else $error("transmit interrupt before shift register empty");
  a_tx_large_raw : assert property (alt_r[1][BIT_HALF_DUP] && alt_r[1][BIT_LARGE_BLK]
      |=> o_tx_int[1] == $past(i_tx_int_req[1]))
    else $error("large block interrupt not passed through");
  a_rx_full_duplex : assert property (!alt_r[0][BIT_HALF_DUP] && !alt_r[0][BIT_INFRARED]
      |=> o_rx_enable[0])
    else $error("receiver off with half duplex clear");
  a_rx_snoop_on : assert property (alt_r[0][BIT_HALF_DUP] && alt_r[0][BIT_SNOOP]
      && tx_pending[0] |=> o_rx_enable[0])
    else $error("snooping receiver muted during transmit");
  a_rx_tx_mute : assert property (alt_r[1][BIT_HALF_DUP] && !alt_r[1][BIT_SNOOP]
      && (tx_pending[1] || de_w[1]) |=> !o_rx_enable[1])
    else $error("receiver live while transmitting");
  a_rx_ir_mute : assert property (!alt_r[0][BIT_HALF_DUP] && alt_r[0][BIT_INFRARED]
      && !alt_r[0][BIT_SNOOP] |=> !o_rx_enable[0])
    else $error("infrared echo not rejected");
  a_rx_snoop_plain : assert property (!alt_r[1][BIT_HALF_DUP] && !alt_r[1][BIT_INFRARED]
      && alt_r[1][BIT_SNOOP] |=> o_rx_enable[1])
    else $error("snoop bit acted in plain mode");
  a_tmo_gated : assert property (!alt_r[0][BIT_SNOOP] |=> !o_rx_tmo_int[0])
    else $error("timeout interrupt with snoop clear");
  a_tmo_passed : assert property (alt_r[1][BIT_SNOOP] && i_rx_tmo_req[1]
      |=> o_rx_tmo_int[1])
    else $error("timeout interrupt lost with snoop set");
  a_de_needs_half : assert property (!alt_r[0][BIT_HALF_DUP] ##1 !alt_r[0][BIT_HALF_DUP]
      |-> !o_line_driver_enable_out[0])
    else $error("driver enable high outside half duplex");
endmodule : ufc_top
`default_nettype wire

// ===== sim/ufc_tx_model.sv
// behavioural transmitter status of one uart channel
`timescale 1ns/1ns
`default_nettype none
module ufc_tx_model #(
  parameter int TICK = 4              // core cycles per bit time
) (
  input  wire logic i_ref_clk,    // core clock
  input  wire logic i_srst,       // sync reset
  input  wire logic i_load,       // one byte pushed per cycle high
  output logic      o_fifo_empty, // no byte queued
  output logic      o_tsr_empty,  // shifter idle
  output logic      o_thr_write,  // fifo write pulse
  output logic      o_stop_warn,  // bit before first stop bit
  output logic      o_bit_tick    // one pulse per bit time
);
  logic [3:0] div_r;
  logic [3:0] bit_r;
  logic [3:0] cnt_r;
  logic       first_r;
  logic       pop;
  assign o_fifo_empty = (cnt_r == 4'h0);
  assign pop          = o_tsr_empty && !o_fifo_empty;
  // shifter empties on a tick, so the next tick is a full bit time away
  always_ff @(posedge i_ref_clk)
  begin
    if (i_srst)
    begin
      div_r       <= 4'h0;
      bit_r       <= 4'h0;
      cnt_r       <= 4'h0;
      first_r     <= 1'b1;
      o_tsr_empty <= 1'b1;
      o_thr_write <= 1'b0;
      o_stop_warn <= 1'b0;
      o_bit_tick  <= 1'b0;
    end
    else
    begin
      div_r       <= (div_r == 4'(TICK - 1)) ? 4'h0 : div_r + 4'h1;
      o_bit_tick  <= (div_r == 4'(TICK - 1));
      o_thr_write <= i_load;
      cnt_r       <= cnt_r + 4'(i_load) - 4'(pop);
      o_stop_warn <= !o_tsr_empty && o_bit_tick && first_r && bit_r == 4'h7;
      if (o_tsr_empty && o_fifo_empty)
        first_r <= 1'b1;
      if (pop)
      begin
        o_tsr_empty <= 1'b0;
        bit_r       <= 4'h0;
      end
      else if (!o_tsr_empty && o_bit_tick)
      begin
        bit_r <= bit_r + 4'h1;
        if (bit_r == 4'h9)
        begin
          o_tsr_empty <= 1'b1;
          first_r     <= 1'b0;
        end
      end
    end
  end
endmodule : ufc_tx_model
`default_nettype wire

// ===== sim/tb_uart_alternate_function_control.sv
// self-checking bench for the uart alternate-function control block
`timescale 1ns/1ns
`default_nettype none
module tb_uart_alternate_function_control
  import ufc_pkg::*;
;
  logic                 ref_clk = 1'b0;
  logic                 srst    = 1'b1;
  logic [ADDR_W-1:0]    addr    = '0;
  logic [DATA_W-1:0]    wdata   = '0;
  logic                 wr_s    = 1'b0;
  logic                 rd_s    = 1'b0;
  logic [CHAN_W-1:0]    chan    = '0;
  logic [LCR_SEL_W-1:0] line_control_register     = '0;
  logic [NUM_CHAN-1:0]  load    = '0;
  logic [NUM_CHAN-1:0]  tx_req  = '0;
  logic [NUM_CHAN-1:0]  tmo_req = '0;
  logic [DATA_W-1:0]    rdata, got, v;
  logic [NUM_CHAN-1:0]  de, tx_int, rx_en, tmo_int, ir;
  logic [NUM_CHAN-1:0]  f_emp, t_emp, thr_wr, stop_w, tick;
  logic [DATA_W-1:0]    shadow [NUM_CHAN];
  logic [7:0]           lfsr_r  = 8'h36;
  logic [CHAN_W-1:0]    c;
  logic [2:0]           a, l;
  int                   fail_count  = 0;
  int                   comparisons = 0;

  ufc_top i_ufc_top (.i_ref_clk(ref_clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_s), .i_rd(rd_s), .i_chan_sel(chan), .i_lcr_upper(line_control_register), .i_fifo_empty(f_emp),
    .i_tsr_empty(t_emp), .i_thr_write(thr_wr), .i_stop_warn(stop_w), .i_bit_tick(tick),
    .i_tx_int_req(tx_req), .i_rx_tmo_req(tmo_req), .o_rdata(rdata),
    .o_line_driver_enable_out(de), .o_tx_int(tx_int), .o_rx_enable(rx_en),
    .o_rx_tmo_int(tmo_int), .o_infrared_mode_enable(ir));
  ufc_tx_model i_ufc_tx_model [NUM_CHAN-1:0] (.i_ref_clk(ref_clk), .i_srst(srst), .i_load(load),
    .o_fifo_empty(f_emp), .o_tsr_empty(t_emp), .o_thr_write(thr_wr), .o_stop_warn(stop_w),
    .o_bit_tick(tick));

  initial
  begin
    forever #2 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // {tx_int, rx_enable, timeout, infrared} expected from register and pending
  function automatic logic [3:0] exp_gate(input logic [7:0] r, input logic tq, mq, pend);
    logic rxe;
    rxe = r[2] ? (r[4] | !pend) : (r[1] ? r[4] : 1'b1);
    return {tq & !(r[2] & !r[3] & pend), rxe, mq & r[4], r[1]};
  endfunction : exp_gate

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic final_report();
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  task automatic bus_wr(input logic [0:0] ch, input logic [2:0] ad, lc, input logic [7:0] d);
    @(posedge ref_clk);
    chan  <= ch;
    addr  <= ad;
    line_control_register   <= lc;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge ref_clk);
    wr_s  <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [0:0] ch, input logic [2:0] ad, lc, output logic [7:0] d);
    @(posedge ref_clk);
    chan <= ch;
    addr <= ad;
    line_control_register  <= lc;
    rd_s <= 1'b1;
    @(posedge ref_clk);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask : bus_rd

  task automatic rd_all();
    for (int k = 0; k < NUM_CHAN; k++)
    begin
      bus_rd(CHAN_W'(k), ALT_FUNC_ADDR, LCR_SEL_ALT, got);
      chk(got, shadow[k]);
    end
  endtask : rd_all

  task automatic chk_gates(input logic [0:0] ch, input logic pend);
    chk({4'h0, tx_int[ch], rx_en[ch], tmo_int[ch], ir[ch]},
        {4'h0, exp_gate(shadow[ch], tx_req[ch], tmo_req[ch], pend)});
  endtask : chk_gates

  // channel 0 sends two bytes; a set top delay bit also reloads during the hold
  task automatic de_run(input logic [7:0] r);
    int k;
    int n;
    bus_wr(1'b0, ALT_FUNC_ADDR, LCR_SEL_ALT, r);
    shadow[0] = r;
    tx_req  <= 2'b11;
    load[0] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    load[0] <= 1'b0;
    #1;
    for (k = 0; k < 400 && stop_w[0] !== 1'b1; k++)
      @(posedge ref_clk) #1;
    chk({7'h0, de[0]}, 8'h00);
    @(posedge ref_clk) #1;
    chk({7'h0, de[0]}, 8'h01);
    chk_gates(1'b0, 1'b1);
    for (int p = 0; p <= int'(r[7]); p++)
    begin
      if (p > 0)
      begin
        load[0] <= 1'b1;
        @(posedge ref_clk);
        load[0] <= 1'b0;
        @(posedge ref_clk) #1;
        chk({7'h0, de[0]}, 8'h01);
      end
      for (k = 0; k < 900 && (f_emp[0] & t_emp[0]) !== 1'b1; k++)
        @(posedge ref_clk) #1;
    end
    n = 0;
    for (k = 0; k < 200 && de[0] === 1'b1; k++)
    begin
      if (tick[0] === 1'b1)
        n++;
      @(posedge ref_clk) #1;
    end
    chk(8'(n), {5'h0, r[7:5]});
  endtask : de_run

  initial
  begin
    shadow[0] = ALT_FUNC_RESET;
    shadow[1] = ALT_FUNC_RESET;
    repeat (12) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk) #1;
    chk({6'h0, rx_en}, 8'h03);
    rd_all();
    $display("done: reset");
    for (int i = 0; i < 40; i++)
    begin
      lfsr_r = lfsr(lfsr_r);
      c = lfsr_r[0];
      tx_req  <= lfsr_r[2:1];
      tmo_req <= lfsr_r[4:3];
      lfsr_r = lfsr(lfsr_r);
      v = {lfsr_r[7:1], 1'b0};
      bus_wr(c, ALT_FUNC_ADDR, LCR_SEL_ALT, v);
      shadow[c] = v;
      repeat (2) @(posedge ref_clk) #1;
      chk_gates(c, 1'b0);
      lfsr_r = lfsr(lfsr_r);
      a = lfsr_r[2:0];
      l = lfsr_r[5:3];
      if (a == ALT_FUNC_ADDR && l == LCR_SEL_ALT)
        l = 3'h0;
      bus_wr(c, a, l, 8'hff);
      bus_rd(c, a, l, got);
      chk(got, READ_IDLE);
      rd_all();
    end
    $display("done: random access");
    bus_wr(1'b0, ALT_FUNC_ADDR, LCR_SEL_ALT, 8'h01);
    bus_wr(1'b0, ALT_FUNC_ADDR, LCR_SEL_ALT, 8'h5a);
    shadow[0] = 8'h5a;
    shadow[1] = 8'h5a;
    rd_all();
    $display("done: broadcast");
    foreach (shadow[k])
      de_run(k == 0 ? 8'h04 : 8'h3c);
    de_run(8'he4);
    de_run(8'h74);
    $display("done: driver enable");
    final_report();
  end

  // the whole sequence needs about a thousand cycles; this allows 25000
  initial
  begin
    #100000;
    fail_count++;
    final_report();
  end
endmodule : tb_uart_alternate_function_control
`default_nettype wire
